// File: rtl/uabd_autobaud.v
// autobaud detection for a serial receive line, apb slave registers included
// assumes rxd is asynchronous to pclk; the remote host idles the line high
// Function
// R1 - detection runs only under enable, out of reset
// R2 - detected flag with enable raises transmit interrupt
// R3 - no repeated interrupts while enable stays set
// R4 - bit13 enable, bit14 write-one clears bit15 flag
// R5 - software preloads divisor of one or slow rate
// R6 - first character A or a sets flag; the code takes any A or a received while armed, not only the first character
// R7 - measured divisor written, interrupt requested
// R8 - handler clears flag, then clears enable
// R9 - software reads calibration character from buffer
// R10 - lock at low rate, reprogram faster later
// R11 - high and low registers form 16-bit divisor
// R12 - start-bit low count over oversampling gives divisor
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "uabd_map.vh"
module uabd_autobaud #(
	parameter CNT_W = 20
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [17:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rxd,
	output reg [15:0] baud_divisor,
	output reg transmit_interrupt_line,
	output reg irq
);

	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_START = 4'b0010;
	localparam [3:0] S_DATA = 4'b0100;
	localparam [3:0] S_STOP = 4'b1000;

	function [16:0] reg_sel;
		input [15:0] idx;
		input [17:0] addr;
		begin
			reg_sel = {1'b0, idx} ^ {1'b0, addr[17:2]};
		end
	endfunction

	// one more count; the width follows CNT_W, so the one is sized here
	function [CNT_W-1:0] cnt_inc;
		input [CNT_W-1:0] v;
		begin
			cnt_inc = v + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// sticky status bit: an event beats a write-one clear in the same cycle
	function w1c_next;
		input cur;
		input set;
		input clr;
		begin
			w1c_next = set | (cur & ~clr);
		end
	endfunction

	reg rx_meta_r, rx_sync_r, rx_prev_r;
	reg [3:0] state_r;
	reg [CNT_W-1:0] cnt_r, bit_time_r;
	reg [2:0] bit_idx_r;
	reg [7:0] shift_r;
	reg [7:0] rx_buf_r;
	reg rx_ready_r;
	reg cal_en_r, detected_r, locked_r, soft_rst_n_r;
	reg [1:0] irq_status_r, irq_mask_r;
	reg [31:0] rdata_nxt;
	reg hit;
	wire setup = psel & ~penable;
	wire wr_acc = psel & penable & pready & pwrite & ~pslverr;
	wire rd_acc = psel & penable & pready & ~pwrite & ~pslverr;
	wire sel_hi = reg_sel(`UABD_IDX_DIV_HIGH, paddr) == 17'h00000;
	wire sel_lo = reg_sel(`UABD_IDX_DIV_LOW, paddr) == 17'h00000;
	wire sel_rx = reg_sel(`UABD_IDX_RX_BUF, paddr) == 17'h00000;
	wire sel_tx = reg_sel(`UABD_IDX_FIFO_TX, paddr) == 17'h00000;
	wire sel_ct = reg_sel(`UABD_IDX_FIFO_CT, paddr) == 17'h00000;
	wire sel_st = reg_sel(`UABD_IDX_IRQ_STATUS, paddr) == 17'h00000;
	wire sel_mk = reg_sel(`UABD_IDX_IRQ_MASK, paddr) == 17'h00000;
	// armed only while out of soft reset, enabled and not yet locked
	wire armed = soft_rst_n_r & cal_en_r & ~locked_r; // [R1] [R3]
	wire [CNT_W-1:0] half_bit = bit_time_r >> 1;
	wire [CNT_W-1:0] div_raw = cnt_r >> `UABD_OVERSAMPLE_LOG2;
	wire char_ok = (shift_r == `UABD_CHAR_UPPER_A) | (shift_r == `UABD_CHAR_LOWER_A);
	wire stop_done = (state_r == S_STOP) & (cnt_r == bit_time_r);
	wire detect_ev = stop_done & rx_sync_r & char_ok & armed; // [R6]
	wire rxchar_ev = stop_done & rx_sync_r;
	wire ct_clear = wr_acc & sel_ct & pwdata[`UABD_BIT_DET_CLEAR];
	reg [15:0] div_meas;

	always @* begin
		// divisor = low-time / oversampling - 1, never below one
		if (div_raw <= {{(CNT_W-1){1'b0}}, 1'b1})
			div_meas = 16'h0001;
		else if (div_raw > {{(CNT_W-16){1'b0}}, 16'hffff})
			div_meas = 16'hffff;
		else
			div_meas = div_raw[15:0] - 16'h0001; // [R12]
	end

	always @* begin
		rdata_nxt = 32'h00000000;
		hit = 1'b1;
		if (sel_hi)
			rdata_nxt[7:0] = baud_divisor[15:8];
		else if (sel_lo)
			rdata_nxt[7:0] = baud_divisor[7:0];
		else if (sel_rx) begin
			rdata_nxt[7:0] = rx_buf_r;
			rdata_nxt[`UABD_BIT_RX_READY] = rx_ready_r;
		end else if (sel_tx)
			rdata_nxt[`UABD_BIT_SOFT_RST] = soft_rst_n_r;
		else if (sel_ct) begin
			rdata_nxt[`UABD_BIT_DETECTED] = detected_r;
			rdata_nxt[`UABD_BIT_CAL_EN] = cal_en_r;
		end else if (sel_st)
			rdata_nxt[1:0] = irq_status_r;
		else if (sel_mk)
			rdata_nxt[1:0] = irq_mask_r;
		else
			hit = 1'b0;
	end

	// zero-wait slave: answer is prepared in setup and shown in access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~hit;
			if (setup && !pwrite)
				prdata <= rdata_nxt;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
			rx_prev_r <= 1'b1;
		end else begin
			rx_meta_r <= rxd;
			rx_sync_r <= rx_meta_r;
			rx_prev_r <= rx_sync_r;
		end
	end

	// measure start low time, then sample 8 data bits and stop at that rate
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_IDLE;
			cnt_r <= {CNT_W{1'b0}};
			bit_time_r <= {CNT_W{1'b0}};
			bit_idx_r <= 3'h0;
			shift_r <= 8'h00;
		end else if (!armed) begin
			state_r <= S_IDLE; // [R1]
			cnt_r <= {CNT_W{1'b0}};
		end else begin
			case (state_r)
				S_IDLE: begin
					cnt_r <= {CNT_W{1'b0}};
					if (rx_prev_r && !rx_sync_r)
						state_r <= S_START;
				end
				S_START: begin
					if (rx_sync_r) begin
						// first data bit of A is one, so the rise ends the start bit
						bit_time_r <= cnt_inc(cnt_r); // [R12]
						cnt_r <= {CNT_W{1'b0}};
						bit_idx_r <= 3'h0;
						state_r <= S_DATA;
					end else if (&cnt_r)
						// a low longer than the counter range is taken as a break, not a start
						state_r <= S_IDLE;
					else
						cnt_r <= cnt_inc(cnt_r);
				end
				S_DATA: begin
					if ((bit_idx_r == 3'h0 && cnt_r == half_bit) ||
						(bit_idx_r != 3'h0 && cnt_r == bit_time_r)) begin
						shift_r <= {rx_sync_r, shift_r[7:1]};
						cnt_r <= {CNT_W{1'b0}};
						bit_idx_r <= bit_idx_r + 3'h1;
						if (bit_idx_r == 3'h7)
							state_r <= S_STOP;
					end else
						// samples sit one bit time plus a clock apart; the drift is tiny
						cnt_r <= cnt_inc(cnt_r);
				end
				S_STOP: begin
					if (cnt_r == bit_time_r) begin
						cnt_r <= {CNT_W{1'b0}};
						state_r <= S_IDLE;
					end else
						// the frame is judged here, near the middle of the stop bit
						cnt_r <= cnt_inc(cnt_r);
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// bit_time_r still holds start length; keep it for the stored divisor
	// a lock in the same cycle as a software byte write wins over the write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_divisor <= `UABD_RST_DIVISOR;
		end else begin
			if (wr_acc && sel_hi)
				baud_divisor[15:8] <= pwdata[7:0]; // [R11]
			if (wr_acc && sel_lo)
				baud_divisor[7:0] <= pwdata[7:0]; // [R11]
			if (detect_ev)
				baud_divisor <= div_meas; // [R7]
		end
	end

	// control bits, detected flag and lock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_en_r <= 1'b0;
			detected_r <= 1'b0;
			locked_r <= 1'b0;
			soft_rst_n_r <= 1'b0;
		end else begin
			if (wr_acc && sel_tx)
				soft_rst_n_r <= pwdata[`UABD_BIT_SOFT_RST];
			if (wr_acc && sel_ct)
				cal_en_r <= pwdata[`UABD_BIT_CAL_EN]; // [R4]
			// a detection in the same cycle as the clear keeps the flag
			if (!soft_rst_n_r)
				detected_r <= 1'b0; // [R1]
			else if (detect_ev)
				detected_r <= 1'b1; // [R6]
			else if (ct_clear)
				detected_r <= 1'b0; // [R4]
			// lock holds until enable is dropped or soft reset is applied, so no second detection
			if (!soft_rst_n_r || !cal_en_r)
				locked_r <= 1'b0;
			else if (detect_ev)
				locked_r <= 1'b1; // [R3]
		end
	end

	// receive buffer: a new character beats the read that would empty it
	// only one character is held; an unread one is overwritten
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf_r <= 8'h00;
			rx_ready_r <= 1'b0;
		end else begin
			if (rxchar_ev && armed) begin
				rx_buf_r <= shift_r;
				rx_ready_r <= 1'b1;
			end else if (rd_acc && sel_rx)
				rx_ready_r <= 1'b0;
		end
	end

	// interrupt status, mask and both interrupt lines
	// the transmit line rises on the same clock as the flag, as it also takes detect_ev
	wire [1:0] st_clr = {2{wr_acc & sel_st}} & pwdata[1:0];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_r <= 2'b00;
			irq_mask_r <= 2'b00;
			transmit_interrupt_line <= 1'b0;
			irq <= 1'b0;
		end else begin
			irq_status_r[`UABD_IRQ_DETECT] <= w1c_next(irq_status_r[`UABD_IRQ_DETECT],
				detect_ev, st_clr[`UABD_IRQ_DETECT]);
			irq_status_r[`UABD_IRQ_RXCHAR] <= w1c_next(irq_status_r[`UABD_IRQ_RXCHAR],
				rxchar_ev & armed, st_clr[`UABD_IRQ_RXCHAR]);
			if (wr_acc && sel_mk)
				irq_mask_r <= pwdata[1:0];
			// the flag line ignores the mask register, as the flag has its own enable in cal_en_r
			transmit_interrupt_line <= soft_rst_n_r & cal_en_r &
				(detected_r | detect_ev); // [R2] [R7]
			irq <= |(irq_status_r & irq_mask_r);
		end
	end

endmodule

// File: rtl/uabd_map.vh
// register indices, field positions and reset values of the autobaud block
// assumes byte address = 4 * index on a 32-bit apb bus
`ifndef UABD_MAP_VH
`define UABD_MAP_VH
`define UABD_IDX_DIV_HIGH 16'h7052
`define UABD_IDX_DIV_LOW 16'h7053
`define UABD_IDX_RX_BUF 16'h7057
`define UABD_IDX_FIFO_TX 16'h705a
`define UABD_IDX_FIFO_CT 16'h705c
`define UABD_IDX_IRQ_STATUS 16'h7060
`define UABD_IDX_IRQ_MASK 16'h7061
`define UABD_BIT_SOFT_RST 15
`define UABD_BIT_DETECTED 15
`define UABD_BIT_DET_CLEAR 14
`define UABD_BIT_CAL_EN 13
`define UABD_BIT_RX_READY 15
`define UABD_IRQ_DETECT 0
`define UABD_IRQ_RXCHAR 1
`define UABD_RST_DIVISOR 16'h0001
`define UABD_CHAR_UPPER_A 8'h41
`define UABD_CHAR_LOWER_A 8'h61
`define UABD_OVERSAMPLE_LOG2 3
`endif

// File: verification/uabd_autobaud_tb.sv
// self-checking bench for the autobaud block with a serial host model
// assumes a zero-wait apb slave and a 40 MHz pclk
`timescale 1ns/100ps
`include "uabd_map.vh"
module uabd_autobaud_tb;
	logic pclk, presetn, psel, penable, pwrite, rxd, pready, pslverr, txi, irq, err;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] bdiv;
	int fails = 0;
	int n_compared = 0;
	uabd_autobaud dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .baud_divisor(bdiv), .transmit_interrupt_line(txi),
		.irq(irq));
	uabd_host host (.pclk(pclk), .rxd(rxd));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task results;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// entered at a rising edge; one idle edge after release avoids re-driving psel
	task apb(input logic w, input logic [15:0] ix, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (k = 0; pready !== 1'b1; k++) begin
			if (k > 50) begin
				fails++;
				results;
			end
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wait_txi(input int n, input logic e);
		int k;
		for (k = 0; k < n; k++) begin
			@(posedge pclk);
			if (txi === 1'b1 && k > 1)
				break;
		end
		cmp(txi, e);
	endtask
	task t_regs;
		cmp(bdiv, 32'h1);
		apb(1'b1, `UABD_IDX_DIV_HIGH, 32'h12);
		apb(1'b1, `UABD_IDX_DIV_LOW, 32'h34);
		cmp(bdiv, 32'h1234);
		apb(1'b0, `UABD_IDX_DIV_HIGH, 32'h0);
		cmp(rd, 32'h12);
		apb(1'b0, 16'h7001, 32'h0);
		cmp(err, 32'h1);
		apb(1'b1, `UABD_IDX_DIV_HIGH, 32'h0);
		apb(1'b1, `UABD_IDX_DIV_LOW, 32'h1);
	endtask
	task t_detect(input logic [7:0] ch, input int bt);
		apb(1'b1, `UABD_IDX_FIFO_TX, 32'h8000);
		apb(1'b1, `UABD_IDX_FIFO_CT, 32'h6000);
		// 'C' opens with a one, so its start bit alone is low and the lock stays armed
		host.send(8'h43, bt);
		wait_txi(20, 1'b0);
		host.send(ch, bt);
		wait_txi(200, 1'b1);
		cmp(bdiv, 32'(bt / 8 - 1));
		cmp(irq, 32'h1);
		apb(1'b0, `UABD_IDX_FIFO_CT, 32'h0);
		cmp(rd, 32'ha000);
		apb(1'b0, `UABD_IDX_RX_BUF, 32'h0);
		cmp(rd, {16'h0, 8'h80, ch});
		apb(1'b1, `UABD_IDX_FIFO_CT, 32'h6000);
		wait_txi(300, 1'b0);
		apb(1'b1, `UABD_IDX_FIFO_CT, 32'h0);
		apb(1'b1, `UABD_IDX_IRQ_MASK, 32'h0);
		@(posedge pclk);
		cmp(irq, 32'h0);
		apb(1'b1, `UABD_IDX_IRQ_MASK, 32'h3);
		apb(1'b1, `UABD_IDX_IRQ_STATUS, 32'h3);
		@(posedge pclk);
		cmp(irq, 32'h0);
	endtask
	task t_soft;
		apb(1'b1, `UABD_IDX_FIFO_TX, 32'h0);
		apb(1'b1, `UABD_IDX_FIFO_CT, 32'h2000);
		host.send(8'h41, 800);
		wait_txi(100, 1'b0);
		cmp(bdiv, 32'h4f);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		apb(1'b1, `UABD_IDX_IRQ_MASK, 32'h3);
		t_detect(8'h41, 480);
		t_detect(8'h61, 640);
		t_soft;
		results;
	end
endmodule
bind uabd_autobaud uabd_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.baud_divisor(baud_divisor), .transmit_interrupt_line(transmit_interrupt_line),
	.irq(irq));

// File: verification/uabd_checker.sv
// assertions on the ports of the autobaud block
// assumes a single pclk domain and an active-low presetn
`timescale 1ns/100ps
`include "uabd_map.vh"
module uabd_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [17:0] paddr,
	input wire [31:0] pwdata,
	input wire [15:0] baud_divisor,
	input wire transmit_interrupt_line,
	input wire irq
);
	wire wr = psel & penable & pwrite;
	wire [15:0] ix = paddr[17:2];
	wire txi = transmit_interrupt_line;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	div_lo_a: assert property (
		wr && ix == `UABD_IDX_DIV_LOW |=> baud_divisor[7:0] == $past(pwdata[7:0]))
		else $error("low divisor byte lost");
	div_hi_a: assert property (
		wr && ix == `UABD_IDX_DIV_HIGH |=> baud_divisor[15:8] == $past(pwdata[7:0]))
		else $error("high divisor byte lost");
	det_int_a: assert property (
		$changed(baud_divisor) && !$past(wr) |=> txi)
		else $error("lock without interrupt");
	no_repeat_a: assert property (
		$rose(txi) |-> $changed(baud_divisor))
		else $error("interrupt without new lock");
	flag_clear_a: assert property (
		wr && ix == `UABD_IDX_FIFO_CT && pwdata[14] |=> ##1 !txi)
		else $error("flag clear ignored");
	cal_off_a: assert property (
		wr && ix == `UABD_IDX_FIFO_CT && !pwdata[13] |=> ##1 !txi)
		else $error("interrupt without enable");
	soft_off_a: assert property (
		wr && ix == `UABD_IDX_FIFO_TX && !pwdata[15] |=> ##1 !txi)
		else $error("interrupt while held off");
	irq_mask_a: assert property (
		wr && ix == `UABD_IDX_IRQ_MASK && pwdata[1:0] == 2'h0 |=> ##1 !irq)
		else $error("masked interrupt seen");
	cover property (wr && ix == `UABD_IDX_FIFO_CT && pwdata[14]);
	cover property ($rose(txi));
	cover property ($fell(irq));
endmodule

// File: verification/uabd_host.sv
// remote host model: sends one 8n1 character at a chosen bit time
// assumes the line idles high between characters
`timescale 1ns/100ps
module uabd_host (
	input wire pclk,
	output logic rxd
);
	initial rxd = 1'b1;
	// bit time in pclk cycles; callers keep it slow for a reliable lock
	task send(input logic [7:0] ch, input int bt);
		logic [9:0] f;
		f = {1'b1, ch, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (bt) @(posedge pclk);
		end
	endtask
endmodule
